// File: inc/fifo_ctrl_pkg.sv
// Constants for the embedded FIFO controller: register map, fields, modes.
// Assumes a 32-bit APB slave with one register per aligned word.
package fifo_ctrl_pkg;
	// Memory block geometry
	localparam int BLOCK_ADDR_W = 12;
	localparam int DATA_W_MAX   = 36;

	// Aspect ratio modes, deepest narrow shape first
	typedef enum logic [2:0] {
		MODE_4K_X1   = 3'h0,
		MODE_2K_X2   = 3'h1,
		MODE_1K_X4   = 3'h2,
		MODE_512_X9  = 3'h3,
		MODE_256_X18 = 3'h4,
		MODE_128_X36 = 3'h5
	} mode_t;

	// Register byte offsets
	localparam logic [7:0] OFS_CONFIG  = 8'h00;
	localparam logic [7:0] OFS_NF_THR  = 8'h04;
	localparam logic [7:0] OFS_NE_THR  = 8'h08;
	localparam logic [7:0] OFS_STATUS  = 8'h0c;
	localparam logic [7:0] OFS_LEVEL   = 8'h10;
	localparam logic [7:0] OFS_CONTROL = 8'h14;

	// Field positions and widths
	localparam int MODE_LSB   = 0;
	localparam int MODE_W     = 3;
	localparam int THR_W      = 16;
	localparam int CLEAR_BIT  = 0;
	localparam int ST_EMPTY   = 0;
	localparam int ST_FULL    = 1;
	localparam int ST_NEAR_E  = 2;
	localparam int ST_NEAR_F  = 3;

	// Reset values
	localparam mode_t           MODE_RST   = MODE_4K_X1;
	localparam logic [15:0]     NF_THR_RST = 16'h0f00;
	localparam logic [15:0]     NE_THR_RST = 16'h0100;
endpackage

// File: core/fifo_ctrl.sv
// Embedded FIFO controller: one push port, one pop port, APB registers.
// Assumes push and pop user logic run on pclk; the APB master runs on pclk too.
// Function
// - One controller serves BLOCKS memory blocks with exactly one write port and one read port.
// - The port shape is selectable from 4k x 1 down to 128 x 36 like the memory block.
// - A word on the push data is stored on each clock edge while push enable is high.
// - The next word is removed and driven on the pop data on each edge while pop enable is high.
// - Writes and reads proceed independently of each other.
// - Both pointers are kept in Gray code and cross between sides through synchronisers.
// - Full is made on the write side and blocks writes while set.
// - Empty is made on the read side and blocks reads while set.
// - Near-full and near-empty flags have programmable thresholds.
// - A FIFO reset returns both pointers to zero and the FIFO to empty.
// - Usable depth follows from the data width and the number of memory blocks.
module fifo_ctrl #(
	parameter int BLOCKS = 1
) (
	// Clock and reset
	input  wire logic                                pclk,
	input  wire logic                                presetn,
	// APB slave
	input  wire logic                                psel,
	input  wire logic                                penable,
	input  wire logic                                pwrite,
	input  wire logic [7:0]                          paddr,
	input  wire logic [31:0]                         pwdata,
	output logic      [31:0]                         prdata,
	output logic                                     pready,
	output logic                                     pslverr,
	// Push port
	input  wire logic                                push_en,
	input  wire logic [fifo_ctrl_pkg::DATA_W_MAX-1:0] push_data_in,
	output logic                                     full_flag,
	output logic                                     near_full_flag,
	// Pop port
	input  wire logic                                pop_en,
	output logic      [fifo_ctrl_pkg::DATA_W_MAX-1:0] pop_data,
	output logic                                     empty_flag,
	output logic                                     near_empty_flag
);
	localparam int AW    = fifo_ctrl_pkg::BLOCK_ADDR_W + $clog2(BLOCKS);
	localparam int PW    = AW + 1;
	localparam int DW    = fifo_ctrl_pkg::DATA_W_MAX;
	localparam int DEPTH = 1 << AW;
	localparam int TW    = fifo_ctrl_pkg::THR_W;

	function automatic logic [PW-1:0] bin2gray(input logic [PW-1:0] b);
		return b ^ (b >> 1);
	endfunction

	function automatic logic [PW-1:0] gray2bin(input logic [PW-1:0] g);
		logic [PW-1:0] b;
		b[PW-1] = g[PW-1];
		for (int i = PW - 2; i >= 0; i--) begin
			b[i] = b[i+1] ^ g[i];
		end
		return b;
	endfunction

	// Depth halves at each wider shape
	function automatic logic [PW-1:0] depth_of(input fifo_ctrl_pkg::mode_t m);
		return PW'(DEPTH) >> m;
	endfunction

	function automatic logic [DW-1:0] mask_of(input fifo_ctrl_pkg::mode_t m);
		case (m)
			fifo_ctrl_pkg::MODE_4K_X1:   return DW'(36'h0_0000_0001);
			fifo_ctrl_pkg::MODE_2K_X2:   return DW'(36'h0_0000_0003);
			fifo_ctrl_pkg::MODE_1K_X4:   return DW'(36'h0_0000_000f);
			fifo_ctrl_pkg::MODE_512_X9:  return DW'(36'h0_0000_01ff);
			fifo_ctrl_pkg::MODE_256_X18: return DW'(36'h0_0003_ffff);
			default:                     return DW'(36'hf_ffff_ffff);
		endcase
	endfunction

	// Registers
	fifo_ctrl_pkg::mode_t mode_q;
	logic [TW-1:0]        nf_thr_q;
	logic [TW-1:0]        ne_thr_q;
	logic                 clr;
	logic                 wr_acc;
	logic                 rd_ready_q;
	logic                 err_q;
	logic [31:0]          prdata_q;

	// Pointers, both sides
	logic [PW-1:0]        wbin_q;
	logic [PW-1:0]        wgray_q;
	logic [PW-1:0]        rbin_q;
	logic [PW-1:0]        rgray_q;
	logic [PW-1:0]        wgray_s1_q;
	logic [PW-1:0]        wgray_s2_q;
	logic [PW-1:0]        rgray_s1_q;
	logic [PW-1:0]        rgray_s2_q;
	logic [PW-1:0]        wcount;
	logic [PW-1:0]        rcount;
	logic [PW-1:0]        depth;
	logic                 do_push;
	logic                 do_pop;
	logic [DW-1:0]        mem [DEPTH];
	logic [DW-1:0]        pop_data_q;

	assign depth = depth_of(mode_q);
	// Each side sees the other pointer only through its synchroniser
	assign wcount = wbin_q - gray2bin(rgray_s2_q);
	assign rcount = gray2bin(wgray_s2_q) - rbin_q;
	assign full_flag       = (wcount >= depth);
	assign empty_flag      = (rcount == '0);
	assign near_full_flag  = (wcount >= PW'(nf_thr_q));
	assign near_empty_flag = (rcount <= PW'(ne_thr_q));
	assign do_push = push_en && !full_flag && !clr;
	assign do_pop  = pop_en && !empty_flag && !clr;
	assign pop_data = pop_data_q;

	// APB: one access cycle, data and error prepared at setup
	assign wr_acc  = psel && penable && pwrite && pready;
	assign pready  = penable && rd_ready_q;
	assign pslverr = pready && err_q;
	assign prdata  = prdata_q;
	assign clr = wr_acc && !err_q && (paddr == fifo_ctrl_pkg::OFS_CONFIG ||
		(paddr == fifo_ctrl_pkg::OFS_CONTROL && pwdata[fifo_ctrl_pkg::CLEAR_BIT]));

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rd_ready_q <= 1'b0;
			err_q      <= 1'b0;
			prdata_q   <= 32'h0000_0000;
		end else if (psel && !penable) begin
			rd_ready_q <= 1'b1;
			err_q      <= 1'b0;
			prdata_q   <= 32'h0000_0000;
			if (paddr == fifo_ctrl_pkg::OFS_CONFIG) begin
				prdata_q[fifo_ctrl_pkg::MODE_LSB +: fifo_ctrl_pkg::MODE_W] <= mode_q;
			end else if (paddr == fifo_ctrl_pkg::OFS_NF_THR) begin
				prdata_q[TW-1:0] <= nf_thr_q;
			end else if (paddr == fifo_ctrl_pkg::OFS_NE_THR) begin
				prdata_q[TW-1:0] <= ne_thr_q;
			end else if (paddr == fifo_ctrl_pkg::OFS_STATUS) begin
				prdata_q[fifo_ctrl_pkg::ST_EMPTY]  <= empty_flag;
				prdata_q[fifo_ctrl_pkg::ST_FULL]   <= full_flag;
				prdata_q[fifo_ctrl_pkg::ST_NEAR_E] <= near_empty_flag;
				prdata_q[fifo_ctrl_pkg::ST_NEAR_F] <= near_full_flag;
			end else if (paddr == fifo_ctrl_pkg::OFS_LEVEL) begin
				prdata_q[PW-1:0] <= wcount;
			end else if (paddr != fifo_ctrl_pkg::OFS_CONTROL) begin
				err_q <= 1'b1;
			end
		end else if (pready) begin
			rd_ready_q <= 1'b0;
		end
	end

	// Writes to read-only offsets are ignored; shape change also clears
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_q   <= fifo_ctrl_pkg::MODE_RST;
			nf_thr_q <= fifo_ctrl_pkg::NF_THR_RST;
			ne_thr_q <= fifo_ctrl_pkg::NE_THR_RST;
		end else if (wr_acc && !err_q) begin
			if (paddr == fifo_ctrl_pkg::OFS_CONFIG) begin
				if (pwdata[fifo_ctrl_pkg::MODE_LSB +: fifo_ctrl_pkg::MODE_W] <=
					fifo_ctrl_pkg::MODE_128_X36) begin
					mode_q <= fifo_ctrl_pkg::mode_t'(
						pwdata[fifo_ctrl_pkg::MODE_LSB +: fifo_ctrl_pkg::MODE_W]);
				end
			end else if (paddr == fifo_ctrl_pkg::OFS_NF_THR) begin
				nf_thr_q <= pwdata[TW-1:0];
			end else if (paddr == fifo_ctrl_pkg::OFS_NE_THR) begin
				ne_thr_q <= pwdata[TW-1:0];
			end
		end
	end

	// Write side pointer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wbin_q  <= '0;
			wgray_q <= '0;
		end else if (clr) begin
			wbin_q  <= '0;
			wgray_q <= '0;
		end else if (do_push) begin
			wbin_q  <= wbin_q + 1'b1;
			wgray_q <= bin2gray(wbin_q + 1'b1);
		end
	end

	// Storage has no reset; only pointers define validity
	always_ff @(posedge pclk) begin
		if (do_push) begin
			mem[wbin_q[AW-1:0] & (depth[AW-1:0] - 1'b1)] <= push_data_in & mask_of(mode_q);
		end
	end

	// Read side pointer and data, apart from the write side
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rbin_q     <= '0;
			rgray_q    <= '0;
			pop_data_q <= '0;
		end else if (clr) begin
			rbin_q     <= '0;
			rgray_q    <= '0;
		end else if (do_pop) begin
			rbin_q     <= rbin_q + 1'b1;
			rgray_q    <= bin2gray(rbin_q + 1'b1);
			pop_data_q <= mem[rbin_q[AW-1:0] & (depth[AW-1:0] - 1'b1)];
		end
	end

	// Gray pointers cross through two flops; one bit moves per step
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wgray_s1_q <= '0;
			wgray_s2_q <= '0;
			rgray_s1_q <= '0;
			rgray_s2_q <= '0;
		end else if (clr) begin
			wgray_s1_q <= '0;
			wgray_s2_q <= '0;
			rgray_s1_q <= '0;
			rgray_s2_q <= '0;
		end else begin
			wgray_s1_q <= wgray_q;
			wgray_s2_q <= wgray_s1_q;
			rgray_s1_q <= rgray_q;
			rgray_s2_q <= rgray_s1_q;
		end
	end

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_full_blocks_push:
		assert property (full_flag && push_en && !clr |=> $stable(wbin_q))
		else $error("push taken while full");
	a_empty_blocks_pop:
		assert property (empty_flag && pop_en && !clr |=> $stable(rbin_q) && $stable(pop_data_q))
		else $error("pop changed state while empty");
	a_push_advances:
		assert property (push_en && !full_flag && !clr |=> wbin_q == $past(wbin_q) + 1'b1)
		else $error("push did not advance write pointer");
	a_pop_advances:
		assert property (pop_en && !empty_flag && !clr |=> rbin_q == $past(rbin_q) + 1'b1)
		else $error("pop did not advance read pointer");
	a_gray_one_bit:
		assert property (!clr |=> $onehot0(wgray_q ^ $past(wgray_q)) &&
			$onehot0(rgray_q ^ $past(rgray_q)))
		else $error("gray pointer moved by more than one bit");
	a_clear_empties:
		assert property (clr |=> empty_flag && !full_flag && wbin_q == '0 && rbin_q == '0)
		else $error("clear did not empty the fifo");
	a_full_at_depth:
		assert property (full_flag |-> wcount == depth)
		else $error("full flag not at configured depth");
	a_near_full_rise:
		assert property ($rose(near_full_flag) && $stable(nf_thr_q) |-> $past(do_push) ||
			$past(clr) || $past(wr_acc))
		else $error("near full rose without a write side cause");
	a_pop_spares_push:
		assert property (pop_en && !push_en && !clr |=> $stable(wbin_q))
		else $error("pop disturbed write pointer");
endmodule

// File: testbench/fifo_user_model.sv
// Partner model: user logic that pushes a counting pattern and pops on request.
// Assumes push and pop ports share pclk with the FIFO controller.
module fifo_user_model (
	// Clock and reset
	input  wire logic                                 pclk,
	input  wire logic                                 presetn,
	// Bench control
	input  wire logic                                 push_req,
	input  wire logic                                 pop_req,
	output logic      [15:0]                          n_pushed,
	// FIFO side
	input  wire logic                                 full_flag,
	output logic                                      push_en,
	output logic      [fifo_ctrl_pkg::DATA_W_MAX-1:0] push_data_in,
	output logic                                      pop_en
);
	timeunit 1ns;
	timeprecision 1ps;

	// Enables and data move only just after pclk, never mid-cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			push_en <= 1'b0;
			pop_en <= 1'b0;
			push_data_in <= 36'h000000001;
			n_pushed <= 16'h0000;
		end else begin
			push_en <= push_req;
			pop_en <= pop_req;
			// Next word only once the current one was taken
			if (push_en && !full_flag) begin
				push_data_in <= push_data_in + 36'h000000001;
				n_pushed <= n_pushed + 16'h0001;
			end
		end
	end
endmodule

// File: testbench/dual_clock_embedded_fifo_controller_test.sv
// Testbench: APB register tasks plus push and pop sequences.
// Assumes fifo_ctrl with BLOCKS = 1 and the user model on its ports.
module dual_clock_embedded_fifo_controller_test;
	timeunit 1ns;
	timeprecision 1ps;

	logic        pclk = 1'b0;
	logic        presetn;
	logic        psel, penable, pwrite, pready, pslverr, er;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	logic        push_en, pop_en, push_req, pop_req;
	logic        full_flag, near_full_flag, empty_flag, near_empty_flag;
	logic [35:0] push_data_in, pop_data;
	logic [15:0] n_pushed;
	int          n_fail = 0;
	int          n_checks = 0;
	int          cyc = 0;

	fifo_ctrl #(.BLOCKS(1)) uut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .push_en(push_en),
		.push_data_in(push_data_in), .full_flag(full_flag),
		.near_full_flag(near_full_flag), .pop_en(pop_en), .pop_data(pop_data),
		.empty_flag(empty_flag), .near_empty_flag(near_empty_flag));
	fifo_user_model model (.pclk(pclk), .presetn(presetn), .push_req(push_req),
		.pop_req(pop_req), .n_pushed(n_pushed), .full_flag(full_flag),
		.push_en(push_en), .push_data_in(push_data_in), .pop_en(pop_en));

	always #5 pclk = ~pclk;

	task automatic report_and_stop;
		if (n_fail == 0 && n_checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask

	// Ceiling well above the roughly 700 cycles the sequence needs
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 20000) begin
			n_fail++;
			report_and_stop;
		end
	end

	task automatic chk(input logic [35:0] got, input logic [35:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Request held from setup until pready is seen high at an edge
	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(a, 1'b1, d);
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		apb(a, 1'b0, 32'h00000000);
		chk(rd, exp);
		chk(er, 1'b0);
	endtask

	// One pop enable, then let the registered data land
	task automatic pop_one;
		@(posedge pclk);
		pop_req <= 1'b1;
		@(posedge pclk);
		pop_req <= 1'b0;
		@(posedge pclk);
		#1;
	endtask

	task automatic wait_cyc(input int n);
		repeat (n) @(posedge pclk);
		#1;
	endtask

	initial begin
		presetn = 1'b0;
		{psel, penable, pwrite, push_req, pop_req} = 5'h00;
		paddr = 8'h00;
		pwdata = 32'h00000000;
		wait_cyc(16);
		chk({empty_flag, full_flag, near_empty_flag, near_full_flag}, 4'ha);
		chk(pop_data, 36'h000000000);
		@(posedge pclk);
		presetn <= 1'b1;
		rd_chk(fifo_ctrl_pkg::OFS_CONFIG, 32'h00000000);
		rd_chk(fifo_ctrl_pkg::OFS_NF_THR, 32'h00000f00);
		rd_chk(fifo_ctrl_pkg::OFS_NE_THR, 32'h00000100);
		rd_chk(fifo_ctrl_pkg::OFS_STATUS, 32'h00000005);
		apb(8'h18, 1'b0, 32'h00000000);
		chk(er, 1'b1);
		chk(rd, 32'h00000000);
		for (int m = 0; m < 6; m++) begin
			wr(fifo_ctrl_pkg::OFS_CONFIG, 32'(m));
			rd_chk(fifo_ctrl_pkg::OFS_CONFIG, 32'(m));
		end
		wr(fifo_ctrl_pkg::OFS_CONFIG, 32'h00000006);
		rd_chk(fifo_ctrl_pkg::OFS_CONFIG, 32'h00000005);
		wr(fifo_ctrl_pkg::OFS_NF_THR, 32'h0000007e);
		wr(fifo_ctrl_pkg::OFS_NE_THR, 32'h00000002);
		wr(fifo_ctrl_pkg::OFS_STATUS, 32'h00000000);
		rd_chk(fifo_ctrl_pkg::OFS_STATUS, 32'h00000005);
		// Push 140 cycles into a 128 deep FIFO: the tail must be refused
		@(posedge pclk);
		push_req <= 1'b1;
		repeat (140) @(posedge pclk);
		push_req <= 1'b0;
		wait_cyc(6);
		chk(n_pushed, 16'h0080);
		chk({empty_flag, full_flag, near_empty_flag, near_full_flag}, 4'h5);
		rd_chk(fifo_ctrl_pkg::OFS_LEVEL, 32'h00000080);
		rd_chk(fifo_ctrl_pkg::OFS_STATUS, 32'h0000000a);
		for (int i = 1; i <= 128; i++) begin
			pop_one;
			chk(pop_data, 36'(i));
			chk(near_empty_flag, (128 - i) <= 2);
		end
		chk(empty_flag, 1'b1);
		pop_one;
		chk(pop_data, 36'h000000080);
		wait_cyc(4);
		rd_chk(fifo_ctrl_pkg::OFS_LEVEL, 32'h00000000);
		@(posedge pclk);
		push_req <= 1'b1;
		repeat (5) @(posedge pclk);
		push_req <= 1'b0;
		wait_cyc(6);
		chk(empty_flag, 1'b0);
		wr(fifo_ctrl_pkg::OFS_CONTROL, 32'h00000001);
		wait_cyc(4);
		chk(empty_flag, 1'b1);
		rd_chk(fifo_ctrl_pkg::OFS_LEVEL, 32'h00000000);
		rd_chk(fifo_ctrl_pkg::OFS_CONTROL, 32'h00000000);
		// Two bit shape keeps only the low data bits: words 134..136 land as 2, 3, 0
		wr(fifo_ctrl_pkg::OFS_CONFIG, 32'h00000001);
		@(posedge pclk);
		push_req <= 1'b1;
		repeat (3) @(posedge pclk);
		push_req <= 1'b0;
		wait_cyc(6);
		pop_one;
		chk(pop_data, 36'h000000002);
		pop_one;
		chk(pop_data, 36'h000000003);
		pop_one;
		chk(pop_data, 36'h000000000);
		chk(empty_flag, 1'b1);
		report_and_stop;
	end
endmodule
